/* logic/tmr_cfg.svh */
`ifndef TMR_CFG_SVH
`define TMR_CFG_SVH
`define A_CTRL_LO 4'h0
`define A_CTRL_HI 4'h1
`define A_MATCH_LO 4'h2
`define A_MATCH_HI 4'h3
`define A_DUTY_LO 4'h4
`define A_DUTY_HI 4'h5
`define A_CFG 4'h6
`define A_CNT_LO 4'h8
`define A_CNT_HI 4'h9
`define CR_FF 7
`define CR_CKS_HI 6
`define CR_CKS_LO 4
`define CR_RUN 3
`define CR_MD_HI 2
`define CR_MD_LO 0
`define CFG_SRC 0
`define CR_RST 8'h00
`define MATCH_RST 8'h00
`define DUTY_RST 8'h00
`define CFG_RST 8'h00
`define PSC_W 11
`define FS_DIV_W 3
`endif

/* logic/tmr_pkg.sv */
package tmr_pkg;
   typedef enum logic [2:0] {
      MD_TIMER8 = 3'h0,
      MD_PDO8 = 3'h1,
      MD_PWM8 = 3'h2,
      MD_LOW16 = 3'h3,
      MD_UP16 = 3'h4
   } mode_t;
   typedef enum logic [2:0] {
      CK_SLOWEST = 3'h0,
      CK_DIV7 = 3'h1,
      CK_DIV5 = 3'h2,
      CK_DIV3 = 3'h3,
      CK_FS = 3'h4,
      CK_DIV1 = 3'h5,
      CK_FC = 3'h6
   } cks_t;
endpackage

/* logic/lane_if.sv */
`timescale 1ns/1ps
interface lane_if;
   logic inc;
   logic clr;
   logic shift;
   logic dwr;
   logic dnow;
   logic [7:0] wdata;
   logic [7:0] cnt;
   logic [7:0] duty;
   modport ctl (output inc, clr, shift, dwr, dnow, wdata, input cnt, duty);
   modport lane (input inc, clr, shift, dwr, dnow, wdata, output cnt, duty);
endinterface

/* logic/duty_lane.sv */
`timescale 1ns/1ps
`include "tmr_cfg.svh"
module duty_lane (
   input wire logic clk,
   input wire logic resetn,
   lane_if.lane p
);
   logic [7:0] cnt_reg;
   logic [7:0] buf_reg;
   logic [7:0] act_reg;

   always_ff @(posedge clk) begin
      if (!resetn) begin
         cnt_reg <= 8'h00;
      end else if (p.clr) begin
         cnt_reg <= 8'h00;
      end else if (p.inc) begin
         cnt_reg <= cnt_reg + 8'h01;
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         buf_reg <= `DUTY_RST;
      end else if (p.dwr) begin
         buf_reg <= p.wdata;
      end
   end

   // [R10] [R11] buffered duty transfer
   always_ff @(posedge clk) begin
      if (!resetn) begin
         act_reg <= `DUTY_RST;
      end else if (p.dwr && p.dnow) begin
         act_reg <= p.wdata;
      end else if (p.shift) begin
         act_reg <= buf_reg;
      end
   end

   assign p.cnt = cnt_reg;
   assign p.duty = act_reg;
endmodule

/* logic/cascade_timer.sv */
// What this block does and what software must do
// [R1] divider compare register unbuffered, used immediately
// [R2] stopped divider output holds its level
// [R3] software changes flop only after stopping
// [R4] bit 3 runs, bit 7 flop value
// [R5] 00010001B selects divider mode, 00011001B starts
// [R6] PWM toggles on duty match, keeps counting
// [R7] PWM overflow toggles, clears, raises interrupt
// [R8] flop loaded from control; reset clears it
// [R9] PWM pin is inverse of flop
// [R10] running duty write waits for overflow
// [R11] stopped duty write takes effect immediately
// [R12] duty read returns active compare value
// [R13] software writes duty right after overflow
// [R14] stopped PWM pin holds its level
// [R15] software stops PWM before stop mode
// [R16] software sets port latch to 1
// [R17] 16-bit match raises upper interrupt, clears
// [R18] software writes low byte then high
// [R19] software keeps flop field 0 in timer
// [R20] 16-bit compare registers unbuffered
// [R21] 13H, 04H, 0CH set up 16-bit timer
// [R22] two identical channels plus cascade logic
`timescale 1ns/1ps
`include "tmr_cfg.svh"
module cascade_timer (
   input wire logic clk,
   input wire logic resetn,
   input wire logic [3:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [7:0] rdata,
   input wire logic fs_tick,
   output logic [1:0] channel_match_irq,
   output logic [1:0] divider_out_pin,
   output logic [1:0] pwm_out_pin
);
   logic [7:0] ctrl_reg [2];
   logic [7:0] match_reg [2];
   logic [7:0] cfg_reg;
   logic [`PSC_W-1:0] psc_reg;
   logic [`FS_DIV_W-1:0] fsd_reg;
   logic [1:0] flop_reg;
   logic [1:0] pin_n_reg;
   logic [1:0] irq_reg;
   logic [7:0] rdata_reg;
   logic [1:0] tick, run, inc, clr, shift, ev, tog, dwr, dnow, wr_ctl;
   logic [7:0] cnt [2];
   logic [7:0] duty [2];
   logic casc;
   logic cascade_run_bit;
   logic prescale_source_select;
   logic fs8;
   logic [15:0] nxt16;

   lane_if lane_c [2] ();

   // [R22] two identical counter lanes
   for (genvar g = 0; g < 2; g++) begin : g_lane
      assign lane_c[g].inc = inc[g];
      assign lane_c[g].clr = clr[g];
      assign lane_c[g].shift = shift[g];
      assign lane_c[g].dwr = dwr[g];
      assign lane_c[g].dnow = dnow[g];
      assign lane_c[g].wdata = wdata;
      assign cnt[g] = lane_c[g].cnt;
      assign duty[g] = lane_c[g].duty;
      duty_lane u_lane (
         .clk(clk),
         .resetn(resetn),
         .p(lane_c[g].lane)
      );
   end

   assign wr_ctl[0] = wr && addr == `A_CTRL_LO;
   assign wr_ctl[1] = wr && addr == `A_CTRL_HI;
   assign dwr[0] = wr && addr == `A_DUTY_LO;
   assign dwr[1] = wr && addr == `A_DUTY_HI;
   assign cascade_run_bit = ctrl_reg[1][`CR_RUN];
   assign prescale_source_select = cfg_reg[`CFG_SRC];
   assign casc = ctrl_reg[1][`CR_MD_HI:`CR_MD_LO] == tmr_pkg::MD_UP16 &&
                 ctrl_reg[0][`CR_MD_HI:`CR_MD_LO] == tmr_pkg::MD_LOW16;
   assign nxt16 = {cnt[1], cnt[0]} + 16'h0001;
   assign fs8 = fs_tick && (&fsd_reg);

   always_ff @(posedge clk) begin
      if (!resetn) begin
         ctrl_reg[0] <= `CR_RST;
         ctrl_reg[1] <= `CR_RST;
         match_reg[0] <= `MATCH_RST;
         match_reg[1] <= `MATCH_RST;
         cfg_reg <= `CFG_RST;
      end else if (wr) begin
         unique case (addr)
            `A_CTRL_LO: ctrl_reg[0] <= wdata;
            `A_CTRL_HI: ctrl_reg[1] <= wdata;
            // [R1] [R20] compare writes act at once
            `A_MATCH_LO: match_reg[0] <= wdata;
            `A_MATCH_HI: match_reg[1] <= wdata;
            `A_CFG: cfg_reg <= wdata;
            default: ;
         endcase
      end
   end

   // free prescaler; each rate is a one-cycle enable
   always_ff @(posedge clk) begin
      if (!resetn) begin
         psc_reg <= '0;
      end else begin
         psc_reg <= psc_reg + 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         fsd_reg <= '0;
      end else if (fs_tick) begin
         fsd_reg <= fsd_reg + 1'b1;
      end
   end

   always_comb begin
      for (int i = 0; i < 2; i++) begin
         unique case (tmr_pkg::cks_t'(ctrl_reg[i][`CR_CKS_HI:`CR_CKS_LO]))
            tmr_pkg::CK_SLOWEST: tick[i] = prescale_source_select ?
                                           fs8 : &psc_reg;
            tmr_pkg::CK_DIV7: tick[i] = &psc_reg[6:0];
            tmr_pkg::CK_DIV5: tick[i] = &psc_reg[4:0];
            tmr_pkg::CK_DIV3: tick[i] = &psc_reg[2:0];
            tmr_pkg::CK_FS: tick[i] = fs_tick;
            tmr_pkg::CK_DIV1: tick[i] = psc_reg[0];
            tmr_pkg::CK_FC: tick[i] = 1'b1;
            default: tick[i] = 1'b0;
         endcase
      end
   end

   always_comb begin
      inc = 2'b00;
      clr = 2'b00;
      ev = 2'b00;
      tog = 2'b00;
      shift = 2'b00;
      run[0] = casc ? cascade_run_bit : ctrl_reg[0][`CR_RUN];
      run[1] = ctrl_reg[1][`CR_RUN];
      if (casc) begin
         if (!cascade_run_bit) begin
            clr = 2'b11;
         end else if (tick[0]) begin
            // [R17] [R21] 16-bit match clears and interrupts
            if (nxt16 == {match_reg[1], match_reg[0]}) begin
               clr = 2'b11;
               ev[1] = 1'b1;
            end else begin
               inc[0] = 1'b1;
               inc[1] = &cnt[0];
            end
         end
      end else begin
         for (int i = 0; i < 2; i++) begin
            if (!run[i]) begin
               clr[i] = 1'b1;
            end else if (tick[i]) begin
               case (tmr_pkg::mode_t'(ctrl_reg[i][`CR_MD_HI:`CR_MD_LO]))
                  tmr_pkg::MD_TIMER8, tmr_pkg::MD_PDO8: begin
                     // [R5] divider toggles on match
                     if (cnt[i] + 8'h01 == match_reg[i]) begin
                        clr[i] = 1'b1;
                        ev[i] = 1'b1;
                        tog[i] = ctrl_reg[i][`CR_MD_LO];
                     end else begin
                        inc[i] = 1'b1;
                     end
                  end
                  tmr_pkg::MD_PWM8: begin
                     // [R7] overflow toggles, clears, shifts duty
                     if (&cnt[i]) begin
                        clr[i] = 1'b1;
                        ev[i] = 1'b1;
                        tog[i] = 1'b1;
                        shift[i] = 1'b1;
                     end else begin
                        // [R6] duty match toggles, no clear
                        inc[i] = 1'b1;
                        tog[i] = cnt[i] + 8'h01 == duty[i];
                     end
                  end
                  default: ;
               endcase
            end
         end
      end
      for (int i = 0; i < 2; i++) begin
         dnow[i] = !run[i] || ctrl_reg[i][`CR_MD_HI:`CR_MD_LO] !=
                   tmr_pkg::MD_PWM8;
      end
   end

   // [R2] [R4] [R8] [R14] flop loads only while already stopped
   always_ff @(posedge clk) begin
      if (!resetn) begin
         flop_reg <= 2'b00;
         pin_n_reg <= 2'b11;
      end else begin
         for (int i = 0; i < 2; i++) begin
            if (wr_ctl[i] && !ctrl_reg[i][`CR_RUN]) begin
               flop_reg[i] <= wdata[`CR_FF];
               pin_n_reg[i] <= !wdata[`CR_FF];
            end else if (tog[i]) begin
               flop_reg[i] <= !flop_reg[i];
               pin_n_reg[i] <= !pin_n_reg[i];
            end
         end
      end
   end

   // [R9] pins drive the inverse of the flop
   assign divider_out_pin = pin_n_reg;
   assign pwm_out_pin = pin_n_reg;

   always_ff @(posedge clk) begin
      if (!resetn) begin
         irq_reg <= 2'b00;
      end else begin
         irq_reg <= ev;
      end
   end
   assign channel_match_irq = irq_reg;

   // [R12] duty reads show the active value
   always_ff @(posedge clk) begin
      if (!resetn) begin
         rdata_reg <= 8'h00;
      end else if (rd) begin
         unique case (addr)
            `A_CTRL_LO: rdata_reg <= ctrl_reg[0];
            `A_CTRL_HI: rdata_reg <= ctrl_reg[1];
            `A_MATCH_LO: rdata_reg <= match_reg[0];
            `A_MATCH_HI: rdata_reg <= match_reg[1];
            `A_DUTY_LO: rdata_reg <= duty[0];
            `A_DUTY_HI: rdata_reg <= duty[1];
            `A_CFG: rdata_reg <= cfg_reg;
            `A_CNT_LO: rdata_reg <= cnt[0];
            `A_CNT_HI: rdata_reg <= cnt[1];
            default: rdata_reg <= 8'h00;
         endcase
      end else begin
         rdata_reg <= 8'h00;
      end
   end
   assign rdata = rdata_reg;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!resetn);

   sequence pwm_run_s;
      !casc && ctrl_reg[1][`CR_RUN] &&
      ctrl_reg[1][`CR_MD_HI:`CR_MD_LO] == tmr_pkg::MD_PWM8;
   endsequence
   sequence pwm_ovf_s;
      pwm_run_s ##0 tick[1] && cnt[1] == 8'hff;
   endsequence

   pin_inverse_a: assert property (pwm_out_pin == ~flop_reg) // [R9]
      else $error("pwm pin not inverse of flop");
   stop_hold_a: assert property ( // [R2]
      !run[0] && !wr_ctl[0] |=> flop_reg[0] == $past(flop_reg[0]))
      else $error("flop moved while stopped");
   flop_load_a: assert property ( // [R4]
      wr_ctl[0] && !ctrl_reg[0][`CR_RUN] |=>
      flop_reg[0] == $past(wdata[`CR_FF]) && pwm_out_pin[0] != flop_reg[0])
      else $error("flop not loaded from control");
   pwm_ovf_a: assert property (pwm_ovf_s |=> // [R7]
      cnt[1] == 8'h00 && channel_match_irq[1] &&
      flop_reg[1] != $past(flop_reg[1]))
      else $error("pwm overflow event wrong");
   pwm_match_a: assert property ( // [R6]
      pwm_run_s ##0 tick[1] && cnt[1] != 8'hff && cnt[1] + 8'h01 == duty[1]
      |=> flop_reg[1] != $past(flop_reg[1]) && cnt[1] == $past(cnt[1]) + 8'h01)
      else $error("pwm duty match wrong");
   duty_wait_a: assert property ( // [R10]
      pwm_run_s ##0 dwr[1] && !(tick[1] && cnt[1] == 8'hff) |=>
      duty[1] == $past(duty[1]))
      else $error("running duty write took effect");
   duty_now_a: assert property ( // [R11]
      dwr[1] && dnow[1] |=> duty[1] == $past(wdata))
      else $error("stopped duty write not applied");
   pdo_match_a: assert property ( // [R5]
      !casc && run[0] && tick[0] && cnt[0] + 8'h01 == match_reg[0] &&
      ctrl_reg[0][`CR_MD_HI:`CR_MD_LO] == tmr_pkg::MD_PDO8 |=>
      cnt[0] == 8'h00 && channel_match_irq[0] &&
      flop_reg[0] != $past(flop_reg[0]))
      else $error("divider match wrong");
   casc_clear_a: assert property ( // [R17]
      casc && cascade_run_bit && tick[0] &&
      nxt16 == {match_reg[1], match_reg[0]} |=>
      cnt[0] == 8'h00 && cnt[1] == 8'h00 && channel_match_irq == 2'b10)
      else $error("16-bit match wrong");
endmodule

/* tb/tb.sv */
`timescale 1ns/1ps
module tb;
   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic [3:0] addr = 4'h0;
   logic [7:0] wdata = 8'h00;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic fs_tick = 1'b0;
   logic [7:0] rdata;
   logic [1:0] channel_match_irq;
   logic [1:0] divider_out_pin;
   logic [1:0] pwm_out_pin;
   int fails = 0;
   int n_tests = 0;
   int seed = 32'h787b;
   int n, lo, k, m, d, d2;
   // prescale codes tried in timer mode and their divide ratios
   logic [2:0] ck_code [3] = '{3'h3, 3'h2, 3'h6};
   int ck_div [3] = '{8, 32, 1};

   cascade_timer dut (
      .clk(clk),
      .resetn(resetn),
      .addr(addr),
      .wdata(wdata),
      .wr(wr),
      .rd(rd),
      .rdata(rdata),
      .fs_tick(fs_tick),
      .channel_match_irq(channel_match_irq),
      .divider_out_pin(divider_out_pin),
      .pwm_out_pin(pwm_out_pin)
   );

   always #5 clk = ~clk;

   // unused low-speed enable still toggles so its path is not idle
   always @(posedge clk) begin
      fs_tick <= (($random(seed) & 7) == 0);
   end

   task end_sim;
      $display("tests %0d fails %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   task chk(input logic [15:0] got, input logic [15:0] exp);
      n_tests++;
      if (got !== exp) begin
         fails++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // cycles between events: ticks times prescale ratio
   function automatic int period(input int ticks, input int div);
      return ticks * div;
   endfunction

   // flop set from duty match up to overflow
   function automatic int low_cycles(input int duty, input int div);
      return (256 - duty) * div;
   endfunction

   task wr_reg(input logic [3:0] a, input logic [7:0] v);
      @(posedge clk);
      addr <= a;
      wdata <= v;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask

   task rd_chk(input logic [3:0] a, input logic [7:0] v);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      chk({8'h00, rdata}, {8'h00, v});
   endtask

   // counts cycles up to and including the next event pulse
   task measure(input int ch, output int cnt, output int low);
      cnt = 0;
      low = 0;
      do begin
         @(posedge clk);
         #1;
         cnt++;
         if (pwm_out_pin[ch] === 1'b0)
            low++;
      end while (channel_match_irq[ch] !== 1'b1 && cnt < 40000);
      if (cnt >= 40000) begin
         fails++;
         $display("mismatch at %0t: got %h expected %h", $time, 0, 1);
      end
   endtask

   task wait_pin_low(input int ch);
      k = 0;
      while (pwm_out_pin[ch] !== 1'b0 && k < 600) begin
         @(posedge clk);
         #1;
         k++;
      end
   endtask

   initial begin
      #1_000_000;
      fails++;
      end_sim();
   end

   initial begin
      repeat (2) @(posedge clk);
      resetn <= 1'b1;
      #1;
      chk({14'h0, divider_out_pin}, 16'h0003);
      chk({14'h0, channel_match_irq}, 16'h0000);
      for (int a = 0; a < 16; a++)
         rd_chk(a[3:0], 8'h00);
      wr_reg(4'h6, 8'h01);
      rd_chk(4'h6, 8'h01);
      wr_reg(4'h6, 8'h00);
      // divider on the lower channel, random match value
      m = 2 + ($random(seed) & 3);
      wr_reg(4'h2, m[7:0]);
      wr_reg(4'h0, 8'h11);
      wr_reg(4'h0, 8'h19);
      measure(0, n, lo);
      measure(0, n, lo);
      chk(16'(n), 16'(period(m, 128)));
      wr_reg(4'h2, 8'h04);
      measure(0, n, lo);
      measure(0, n, lo);
      chk(16'(n), 16'(period(4, 128)));
      measure(0, n, lo);
      repeat (2) @(posedge clk);
      #1;
      chk({15'h0, divider_out_pin[0]}, 16'h0000);
      wr_reg(4'h0, 8'h11);
      repeat (700) @(posedge clk);
      #1;
      chk({15'h0, divider_out_pin[0]}, 16'h0000);
      chk({15'h0, pwm_out_pin[0]}, 16'h0000);
      // flop changed in a later write
      wr_reg(4'h0, 8'h01);
      repeat (2) @(posedge clk);
      #1;
      chk({15'h0, divider_out_pin[0]}, 16'h0001);
      wr_reg(4'h0, 8'h81);
      repeat (2) @(posedge clk);
      #1;
      chk({15'h0, divider_out_pin[0]}, 16'h0000);
      // timer mode at three rates, flop field 0
      for (int c = 0; c < 3; c++) begin
         wr_reg(4'h0, {1'b0, ck_code[c], 4'h0});
         m = 2 + ($random(seed) & 3);
         wr_reg(4'h2, m[7:0]);
         wr_reg(4'h0, {1'b0, ck_code[c], 4'h8});
         measure(0, n, lo);
         measure(0, n, lo);
         chk(16'(n), 16'(period(m, ck_div[c])));
         chk({15'h0, divider_out_pin[0]}, 16'h0001);
      end
      wr_reg(4'h0, 8'h00);
      // pwm on the upper channel at clk/2
      d = 2 + ({$random(seed)} % 253);
      d2 = 2 + ({$random(seed)} % 253);
      wr_reg(4'h5, d[7:0]);
      rd_chk(4'h5, d[7:0]);
      wr_reg(4'h1, 8'h52);
      wr_reg(4'h1, 8'h5a);
      measure(1, n, lo);
      measure(1, n, lo);
      chk(16'(n), 16'(period(256, 2)));
      chk(16'(lo), 16'(low_cycles(d, 2)));
      wr_reg(4'h5, d2[7:0]);
      rd_chk(4'h5, d[7:0]);
      measure(1, n, lo);
      measure(1, n, lo);
      chk(16'(lo), 16'(low_cycles(d2, 2)));
      rd_chk(4'h5, d2[7:0]);
      wait_pin_low(1);
      wr_reg(4'h1, 8'h52);
      repeat (600) @(posedge clk);
      #1;
      // pin seen as with port latch 1
      chk({15'h0, pwm_out_pin[1]}, 16'h0000);
      chk({15'h0, divider_out_pin[1]}, 16'h0000);
      wr_reg(4'h1, 8'h52);
      repeat (2) @(posedge clk);
      #1;
      chk({15'h0, pwm_out_pin[1]}, 16'h0001);
      // cascade compare 0x0101, low byte first
      wr_reg(4'h2, 8'h01);
      wr_reg(4'h3, 8'h01);
      wr_reg(4'h0, 8'h13);
      wr_reg(4'h1, 8'h04);
      wr_reg(4'h1, 8'h0c);
      measure(1, n, lo);
      measure(1, n, lo);
      chk(16'(n), 16'(period(257, 128)));
      wr_reg(4'h1, 8'h04);
      rd_chk(4'h8, 8'h00);
      end_sim();
   end
endmodule
